// file: include/edpc_defs.vh
`ifndef EDPC_DEFS_VH
`define EDPC_DEFS_VH

// Register byte offsets
`define EDPC_ADDR_W           12
`define EDPC_OFF_CTRL         12'h000
`define EDPC_OFF_INT_STAT     12'h004
`define EDPC_OFF_INT_MASK     12'h008

// Control/status register fields
`define EDPC_B_EN             15
`define EDPC_B_AUTO_UP        14
`define EDPC_B_AUTO_DOWN      13
`define EDPC_B_MAN            12
`define EDPC_B_BURST_DIS      11
`define EDPC_B_PWR            10
`define EDPC_B_ERR_MET        9
`define EDPC_B_DATA_MET       8
`define EDPC_F_ERR_THR        7:4
`define EDPC_F_DATA_THR       3:0
`define EDPC_F_HI_BYTE        15:8
`define EDPC_F_LO_BYTE        7:0
`define EDPC_THR_W            4

// Reset values
`define EDPC_RST_AUTO_UP      1'b1
`define EDPC_RST_AUTO_DOWN    1'b1
`define EDPC_RST_THR          4'h1

// Interrupt status and mask layout
`define EDPC_INT_W            3
`define EDPC_I_DATA           0
`define EDPC_I_ERR            1
`define EDPC_I_PWR            2
`define EDPC_F_INT            2:0

// Power states, one-hot
`define EDPC_ST_DOWN          2'h1
`define EDPC_ST_UP            2'h2

// Bus responses
`define EDPC_RESP_OKAY        2'h0
`define EDPC_RESP_SLVERR      2'h2

// Timing
`define EDPC_CLK_PERIOD_NS    50
`define EDPC_IDLE_TIME_MS     2000
`define EDPC_IDLE_CYCLES      (`EDPC_IDLE_TIME_MS * (1000000 / `EDPC_CLK_PERIOD_NS))
`define EDPC_PULSE_GAP_NS     1000
`define EDPC_PULSE_GAP_CYCLES (`EDPC_PULSE_GAP_NS / `EDPC_CLK_PERIOD_NS)
`define EDPC_BURST_LEN        4

`endif

// file: logic/edpc_event_counter.v
`timescale 1ns/1ps
`default_nettype none
`include "edpc_defs.vh"

module edpc_event_counter #(
	parameter WIDTH = `EDPC_THR_W
) (
	input  wire             aclk,
	input  wire             aresetn,
	input  wire             clr,
	input  wire             evt,
	input  wire [WIDTH-1:0] thresh,
	output reg              met_r
);
	reg  [WIDTH-1:0] cnt_r;
	wire [WIDTH-1:0] cnt_nxt;

	// Saturates so a noisy line cannot wrap the count back below threshold
	assign cnt_nxt = (evt && (cnt_r != {WIDTH{1'b1}})) ? cnt_r + {{(WIDTH-1){1'b0}}, 1'b1} : cnt_r;

	always @(posedge aclk) begin
		if (!aresetn || clr) begin
			cnt_r <= {WIDTH{1'b0}};
			met_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			met_r <= (cnt_nxt >= thresh) && (cnt_nxt != {WIDTH{1'b0}});
		end
	end
endmodule // edpc_event_counter

`default_nettype wire

// file: logic/edpc_pulse_burst.v
`timescale 1ns/1ps
`default_nettype none
`include "edpc_defs.vh"

module edpc_pulse_burst #(
	parameter BURST_LEN  = `EDPC_BURST_LEN,
	parameter GAP_CYCLES = `EDPC_PULSE_GAP_CYCLES
) (
	input  wire aclk,
	input  wire aresetn,
	input  wire start,
	input  wire single,
	output reg  pulse_r
);
	localparam [31:0] LEN_FULL = BURST_LEN;
	localparam [31:0] GAP_FULL = GAP_CYCLES - 1;
	// Limitation: burst length up to 15 and gap up to 65536 cycles fit these counters
	localparam [3:0]  LEN      = LEN_FULL[3:0];
	localparam [15:0] GAP_LAST = GAP_FULL[15:0];

	reg [3:0]  left_r;
	reg [15:0] gap_r;

	always @(posedge aclk) begin
		if (!aresetn) begin
			left_r  <= 4'h0;
			gap_r   <= 16'h0000;
			pulse_r <= 1'b0;
		end else begin
			pulse_r <= 1'b0;
			if (start) begin
				left_r <= single ? 4'h1 : LEN;
				gap_r  <= 16'h0000;
			end else if (left_r != 4'h0) begin
				if (gap_r == 16'h0000) begin
					pulse_r <= 1'b1;
					left_r  <= left_r - 4'h1;
					gap_r   <= GAP_LAST;
				end else begin
					gap_r <= gap_r - 16'h0001;
				end
			end
		end
	end
endmodule // edpc_pulse_burst

`default_nettype wire

// file: logic/edpc_top.v
// Design decisions made here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "edpc_defs.vh"

// Summary of operation
// - Energy detect acts only while enable bit 15 is set; reset value from strap.
// - Auto power-up bit 14, default 1, powers up once data threshold reached.
// - Auto power-down bit 13, default 1, powers down when line has no energy.
// - Self-clearing bit 12 toggles power state ignoring thresholds and timers.
// - With burst disable 0, send four detect pulses at each power-up made while energy detect is enabled.
// - With burst disable set, send one detect pulse at each power-up made while energy detect is enabled.
// - Read-only bit 10 shows power state, 1 up, 0 down.
// - Bit 9 flags error threshold met, no action taken, cleared on read.
// - Bit 8 flags data count reached threshold, cleared on read.
// - Bits 7:4 hold error threshold, reset 0001.
// - Bits 3:0 hold data threshold, reset 0001.
// - Event counters reset after two seconds without a data event.
module edpc_top #(
	parameter ADDR_W      = `EDPC_ADDR_W,
	parameter IDLE_CYCLES = `EDPC_IDLE_CYCLES
) (
	input  wire              aclk,
	input  wire              aresetn,
	input  wire [ADDR_W-1:0] s_axi_awaddr,
	input  wire [2:0]        s_axi_awprot,
	input  wire              s_axi_awvalid,
	output reg               s_axi_awready,
	input  wire [31:0]       s_axi_wdata,
	input  wire [3:0]        s_axi_wstrb,
	input  wire              s_axi_wvalid,
	output reg               s_axi_wready,
	output reg  [1:0]        s_axi_bresp,
	output reg               s_axi_bvalid,
	input  wire              s_axi_bready,
	input  wire [ADDR_W-1:0] s_axi_araddr,
	input  wire [2:0]        s_axi_arprot,
	input  wire              s_axi_arvalid,
	output reg               s_axi_arready,
	output reg  [31:0]       s_axi_rdata,
	output reg  [1:0]        s_axi_rresp,
	output reg               s_axi_rvalid,
	input  wire              s_axi_rready,
	input  wire              energy_detect_strap,
	input  wire              data_event,
	input  wire              error_event,
	input  wire              no_energy,
	output reg               line_driver_power_r,
	output wire              detect_pulse,
	output reg               irq_r
);
	localparam [31:0] IDLE_LAST = IDLE_CYCLES - 1;
	localparam [1:0]  ST_DOWN   = `EDPC_ST_DOWN;
	localparam [1:0]  ST_UP     = `EDPC_ST_UP;

	// One-hot register select: [0] control, [1] int status, [2] int mask
	function [2:0] reg_sel;
		input [ADDR_W-1:0] a;
		begin
			reg_sel = {a == `EDPC_OFF_INT_MASK, a == `EDPC_OFF_INT_STAT, a == `EDPC_OFF_CTRL};
		end
	endfunction

	reg                   energy_detect_enable;
	reg                   auto_power_up_enable;
	reg                   auto_power_down_enable;
	reg                   manual_power_toggle;
	reg                   pulse_burst_disable;
	reg                   error_threshold_met;
	reg                   data_threshold_met;
	reg  [`EDPC_THR_W-1:0] error_event_threshold;
	reg  [`EDPC_THR_W-1:0] data_event_threshold;
	reg                   strap_done_r;
	reg  [1:0]            state_r;
	reg  [1:0]            state_nxt;
	reg  [31:0]           idle_cnt_r;
	reg                   idle_to_r;
	reg                   data_lvl_d_r;
	reg                   err_lvl_d_r;
	reg  [`EDPC_INT_W-1:0] int_stat_r;
	reg  [`EDPC_INT_W-1:0] int_mask_r;
	reg  [`EDPC_INT_W-1:0] int_set;
	reg                   aw_full_r;
	reg                   w_full_r;
	reg  [ADDR_W-1:0]     awaddr_r;
	reg  [31:0]           wdata_r;
	reg  [3:0]            wstrb_r;
	reg  [1:0]            cor_snap_r;
	reg  [15:0]           ctrl_rd;
	wire                  data_lvl;
	wire                  err_lvl;
	wire                  cnt_clr;
	wire                  pwr_chg;
	wire                  wr_do;
	wire [2:0]            wsel;
	wire [2:0]            rsel;
	wire                  rd_done;
	wire                  data_rise;
	wire                  err_rise;

	assign wr_do     = aw_full_r && w_full_r && !s_axi_bvalid;
	assign wsel      = reg_sel(awaddr_r);
	assign rsel      = reg_sel(s_axi_araddr);
	assign rd_done   = s_axi_rvalid && s_axi_rready;
	assign pwr_chg   = (state_nxt != state_r) && energy_detect_enable;
	assign cnt_clr   = idle_to_r || pwr_chg || !energy_detect_enable;
	assign data_rise = data_lvl && !data_lvl_d_r;
	assign err_rise  = err_lvl && !err_lvl_d_r;

	edpc_event_counter #(.WIDTH(`EDPC_THR_W)) u_data_cnt (
		.aclk    (aclk),
		.aresetn (aresetn),
		.clr     (cnt_clr),
		.evt     (data_event),
		.thresh  (data_event_threshold),
		.met_r   (data_lvl)
	);

	edpc_event_counter #(.WIDTH(`EDPC_THR_W)) u_err_cnt (
		.aclk    (aclk),
		.aresetn (aresetn),
		.clr     (cnt_clr),
		.evt     (error_event),
		.thresh  (error_event_threshold),
		.met_r   (err_lvl)
	);

	// Burst starts on each power-up while energy detect is enabled, not when clearing the enable powers the driver
	edpc_pulse_burst #(
		.BURST_LEN  (`EDPC_BURST_LEN),
		.GAP_CYCLES (`EDPC_PULSE_GAP_CYCLES)
	) u_burst (
		.aclk    (aclk),
		.aresetn (aresetn),
		.start   (pwr_chg && (state_nxt == ST_UP)),
		.single  (pulse_burst_disable),
		.pulse_r (detect_pulse)
	);

	// Power state decision; error counts never move it
	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_DOWN: begin
				if (manual_power_toggle) begin
					state_nxt = ST_UP;
				end else if (auto_power_up_enable && data_lvl) begin
					state_nxt = ST_UP;
				end
			end
			ST_UP: begin
				if (manual_power_toggle) begin
					state_nxt = ST_DOWN;
				end else if (auto_power_down_enable && no_energy) begin
					state_nxt = ST_DOWN;
				end
			end
			default: state_nxt = ST_UP;
		endcase
		// Without energy detect the port simply stays powered
		if (!energy_detect_enable) begin
			state_nxt = ST_UP;
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			state_r             <= ST_UP;
			line_driver_power_r <= 1'b1;
			idle_cnt_r          <= 32'h00000000;
			idle_to_r           <= 1'b0;
			data_lvl_d_r        <= 1'b0;
			err_lvl_d_r         <= 1'b0;
		end else begin
			state_r             <= state_nxt;
			line_driver_power_r <= (state_nxt == ST_UP);
			data_lvl_d_r        <= data_lvl;
			err_lvl_d_r         <= err_lvl;
			idle_to_r           <= 1'b0;
			if (data_event || !energy_detect_enable) begin
				idle_cnt_r <= 32'h00000000;
			end else if (idle_cnt_r == IDLE_LAST) begin
				idle_cnt_r <= 32'h00000000;
				idle_to_r  <= 1'b1;
			end else begin
				idle_cnt_r <= idle_cnt_r + 32'h00000001;
			end
		end
	end

	always @* begin
		int_set                = {`EDPC_INT_W{1'b0}};
		int_set[`EDPC_I_DATA]  = data_rise;
		int_set[`EDPC_I_ERR]   = err_rise;
		int_set[`EDPC_I_PWR]   = pwr_chg;
		ctrl_rd                = 16'h0000;
		ctrl_rd[`EDPC_B_EN]        = energy_detect_enable;
		ctrl_rd[`EDPC_B_AUTO_UP]   = auto_power_up_enable;
		ctrl_rd[`EDPC_B_AUTO_DOWN] = auto_power_down_enable;
		ctrl_rd[`EDPC_B_MAN]       = manual_power_toggle;
		ctrl_rd[`EDPC_B_BURST_DIS] = pulse_burst_disable;
		ctrl_rd[`EDPC_B_PWR]       = (state_r == ST_UP);
		ctrl_rd[`EDPC_B_ERR_MET]   = error_threshold_met;
		ctrl_rd[`EDPC_B_DATA_MET]  = data_threshold_met;
		ctrl_rd[`EDPC_F_ERR_THR]   = error_event_threshold;
		ctrl_rd[`EDPC_F_DATA_THR]  = data_event_threshold;
	end

	// Register file and flags
	always @(posedge aclk) begin
		if (!aresetn) begin
			energy_detect_enable   <= 1'b0;
			strap_done_r           <= 1'b0;
			auto_power_up_enable   <= `EDPC_RST_AUTO_UP;
			auto_power_down_enable <= `EDPC_RST_AUTO_DOWN;
			manual_power_toggle    <= 1'b0;
			pulse_burst_disable    <= 1'b0;
			error_event_threshold  <= `EDPC_RST_THR;
			data_event_threshold   <= `EDPC_RST_THR;
			error_threshold_met    <= 1'b0;
			data_threshold_met     <= 1'b0;
			int_stat_r             <= {`EDPC_INT_W{1'b0}};
			int_mask_r             <= {`EDPC_INT_W{1'b0}};
			irq_r                  <= 1'b0;
		end else begin
			// Strap is caught once, on the first edge after reset release
			if (!strap_done_r) begin
				strap_done_r         <= 1'b1;
				energy_detect_enable <= energy_detect_strap;
			end
			// Manual request is consumed by the state machine in one cycle
			manual_power_toggle <= 1'b0;
			if (wr_do && wsel[0] && s_axi_bresp == `EDPC_RESP_OKAY) begin
				if (wstrb_r[1]) begin
					if (strap_done_r) begin
						energy_detect_enable <= wdata_r[`EDPC_B_EN];
					end
					auto_power_up_enable   <= wdata_r[`EDPC_B_AUTO_UP];
					auto_power_down_enable <= wdata_r[`EDPC_B_AUTO_DOWN];
					manual_power_toggle    <= wdata_r[`EDPC_B_MAN];
					pulse_burst_disable    <= wdata_r[`EDPC_B_BURST_DIS];
				end
				if (wstrb_r[0]) begin
					error_event_threshold <= wdata_r[`EDPC_F_ERR_THR];
					data_event_threshold  <= wdata_r[`EDPC_F_DATA_THR];
				end
			end
			// Only bits returned by the finished read are cleared; new sets win
			error_threshold_met <= (error_threshold_met && !(rd_done && cor_snap_r[1]))
				|| err_rise;
			data_threshold_met  <= (data_threshold_met && !(rd_done && cor_snap_r[0]))
				|| data_rise;
			if (wr_do && wsel[2] && wstrb_r[0]) begin
				int_mask_r <= wdata_r[`EDPC_F_INT];
			end
			if (wr_do && wsel[1] && wstrb_r[0]) begin
				int_stat_r <= (int_stat_r & ~wdata_r[`EDPC_F_INT]) | int_set;
			end else begin
				int_stat_r <= int_stat_r | int_set;
			end
			irq_r <= |(int_stat_r & int_mask_r);
		end
	end

	// AXI4-Lite slave: address and data taken in either order, one of each in flight
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `EDPC_RESP_OKAY;
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `EDPC_RESP_OKAY;
			aw_full_r     <= 1'b0;
			w_full_r      <= 1'b0;
			awaddr_r      <= {ADDR_W{1'b0}};
			wdata_r       <= 32'h00000000;
			wstrb_r       <= 4'h0;
			cor_snap_r    <= 2'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awready <= 1'b0;
				aw_full_r     <= 1'b1;
				awaddr_r      <= s_axi_awaddr;
				s_axi_bresp   <= (reg_sel(s_axi_awaddr) != 3'h0) ? `EDPC_RESP_OKAY
					: `EDPC_RESP_SLVERR;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wready <= 1'b0;
				w_full_r     <= 1'b1;
				wdata_r      <= s_axi_wdata;
				wstrb_r      <= s_axi_wstrb;
			end
			if (wr_do) begin
				aw_full_r    <= 1'b0;
				w_full_r     <= 1'b0;
				s_axi_bvalid <= 1'b1;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rresp   <= (rsel != 3'h0) ? `EDPC_RESP_OKAY : `EDPC_RESP_SLVERR;
				s_axi_rdata   <= rsel[0] ? {16'h0000, ctrl_rd}
					: rsel[1] ? {29'h00000000, int_stat_r}
					: rsel[2] ? {29'h00000000, int_mask_r} : 32'h00000000;
				cor_snap_r    <= rsel[0] ? {error_threshold_met, data_threshold_met}
					: 2'h0;
			end
			if (rd_done) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
				cor_snap_r    <= 2'h0;
			end
		end
	end
endmodule // edpc_top

`default_nettype wire

// file: verification/edpc_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module edpc_monitor (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        data_event,
	input wire logic        no_energy,
	input wire logic        line_driver_power_r,
	input wire logic        detect_pulse
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Only same-edge offers are judged; split offers leave this vacuous
	wire wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	AST_WR_ANSWER: assert property (wr_go |-> ##2 s_axi_bvalid)
		else $error("write not answered");
	AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
	AST_UPPER_ZERO: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
		else $error("upper read bits set");
	AST_PULSE_SINGLE: assert property (detect_pulse |=> !detect_pulse)
		else $error("detect pulse too long");
	AST_BURST_LEAD: assert property ($rose(line_driver_power_r) |=> detect_pulse)
		else $error("no pulse after power up");
	AST_DOWN_CAUSE: assert property ($fell(line_driver_power_r) |->
		$past(no_energy, 1) || $past(s_axi_bvalid, 1))
		else $error("power down without cause");
	AST_UP_CAUSE: assert property ($rose(line_driver_power_r) |->
		$past(data_event, 2) || $past(s_axi_bvalid, 1) || $past(s_axi_bvalid, 2))
		else $error("power up without cause");
	COV_UP: cover property ($rose(line_driver_power_r));
	COV_DOWN: cover property ($fell(line_driver_power_r));
	COV_READ: cover property (s_axi_rvalid && s_axi_rready);
endmodule // edpc_monitor
bind edpc_top edpc_monitor u_edpc_monitor (
	.aclk                (aclk),
	.aresetn             (aresetn),
	.s_axi_awvalid       (s_axi_awvalid),
	.s_axi_awready       (s_axi_awready),
	.s_axi_wvalid        (s_axi_wvalid),
	.s_axi_wready        (s_axi_wready),
	.s_axi_bvalid        (s_axi_bvalid),
	.s_axi_arvalid       (s_axi_arvalid),
	.s_axi_arready       (s_axi_arready),
	.s_axi_rvalid        (s_axi_rvalid),
	.s_axi_rready        (s_axi_rready),
	.s_axi_rdata         (s_axi_rdata),
	.data_event          (data_event),
	.no_energy           (no_energy),
	.line_driver_power_r (line_driver_power_r),
	.detect_pulse        (detect_pulse)
);
`default_nettype wire

// file: verification/edpc_link_partner.sv
`timescale 1ns/1ps
`default_nettype none
module edpc_link_partner (
	input  wire logic aclk,
	input  wire logic detect_pulse,
	output var logic  data_event,
	output var logic  error_event,
	output var logic  no_energy
);
	int pulses = 0;
	initial begin
		data_event = 1'b0;
		error_event = 1'b0;
		no_energy = 1'b0;
	end
	always @(posedge aclk) begin
		if (detect_pulse)
			pulses <= pulses + 1;
	end
	// A long gap models a slow, sparse line
	task send(input logic err, input int n, input int gap);
		repeat (n) begin
			@(posedge aclk);
			error_event <= err;
			data_event <= !err;
			@(posedge aclk);
			error_event <= 1'b0;
			data_event <= 1'b0;
			repeat (gap) @(posedge aclk);
		end
	endtask
	task quiet(input int n);
		@(posedge aclk);
		no_energy <= 1'b1;
		repeat (n) @(posedge aclk);
		no_energy <= 1'b0;
	endtask
endmodule // edpc_link_partner
`default_nettype wire

// file: verification/edpc_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module edpc_tb_top;
	logic aclk = 1'b0, aresetn = 1'b0, energy_detect_strap = 1'b1;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [31:0] s_axi_wdata = 32'h00000000;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire data_event, error_event, no_energy, line_driver_power_r, detect_pulse, irq_r;
	int failures = 0;
	int samples_checked = 0;
	// Idle timeout cut to 50 cycles so the two-second wait fits the run
	edpc_top #(.IDLE_CYCLES(50)) u_edpc_top (
		.aclk                (aclk),
		.aresetn             (aresetn),
		.s_axi_awaddr        (s_axi_awaddr),
		.s_axi_awprot        (s_axi_awprot),
		.s_axi_awvalid       (s_axi_awvalid),
		.s_axi_awready       (s_axi_awready),
		.s_axi_wdata         (s_axi_wdata),
		.s_axi_wstrb         (s_axi_wstrb),
		.s_axi_wvalid        (s_axi_wvalid),
		.s_axi_wready        (s_axi_wready),
		.s_axi_bresp         (s_axi_bresp),
		.s_axi_bvalid        (s_axi_bvalid),
		.s_axi_bready        (s_axi_bready),
		.s_axi_araddr        (s_axi_araddr),
		.s_axi_arprot        (s_axi_arprot),
		.s_axi_arvalid       (s_axi_arvalid),
		.s_axi_arready       (s_axi_arready),
		.s_axi_rdata         (s_axi_rdata),
		.s_axi_rresp         (s_axi_rresp),
		.s_axi_rvalid        (s_axi_rvalid),
		.s_axi_rready        (s_axi_rready),
		.energy_detect_strap (energy_detect_strap),
		.data_event          (data_event),
		.error_event         (error_event),
		.no_energy           (no_energy),
		.line_driver_power_r (line_driver_power_r),
		.detect_pulse        (detect_pulse),
		.irq_r               (irq_r)
	);
	edpc_link_partner u_edpc_link_partner (
		.aclk         (aclk),
		.detect_pulse (detect_pulse),
		.data_event   (data_event),
		.error_event  (error_event),
		.no_energy    (no_energy)
	);
	always #25 aclk = ~aclk;
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wrap_up;
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		// Wait ends once s_axi_bvalid is seen; the watchdog ends it only if no response comes
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp, er);
	endtask
	task rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata, exp);
		chk(s_axi_rresp, er);
	endtask
	// With stay set the level must hold for the whole window
	task pwr(input logic v, input logic stay);
		int n;
		for (n = 0; n < 10 && (stay || line_driver_power_r !== v); n++) begin
			@(posedge aclk);
			if (stay) chk(line_driver_power_r, v);
		end
		chk(line_driver_power_r, v);
	endtask
	task t_reset;
		rd(12'h000, 32'h0000E411, 2'h0);
		rd(12'h008, 32'h00000000, 2'h0);
		rd(12'h00C, 32'h00000000, 2'h2);
		wr(12'h010, 32'h0000FFFF, 2'h2);
		s_axi_wstrb <= 4'h1;
		wr(12'h000, 32'h00000033, 2'h0);
		s_axi_wstrb <= 4'hF;
		rd(12'h000, 32'h0000E433, 2'h0);
	endtask
	task t_auto;
		wr(12'h000, 32'h0000E011, 2'h0);
		u_edpc_link_partner.quiet(1);
		pwr(1'b0, 1'b0);
		rd(12'h000, 32'h0000E011, 2'h0);
		u_edpc_link_partner.pulses = 0;
		u_edpc_link_partner.send(1'b0, 1, 0);
		pwr(1'b1, 1'b0);
		repeat (100) @(posedge aclk);
		chk(u_edpc_link_partner.pulses, 4);
		chk(irq_r, 1'b0);
		rd(12'h004, 32'h00000005, 2'h0);
		rd(12'h000, 32'h0000E511, 2'h0);
		rd(12'h000, 32'h0000E411, 2'h0);
		wr(12'h008, 32'h00000007, 2'h0);
		repeat (3) @(posedge aclk);
		chk(irq_r, 1'b1);
		wr(12'h004, 32'h00000007, 2'h0);
		repeat (3) @(posedge aclk);
		chk(irq_r, 1'b0);
	endtask
	task t_manual;
		wr(12'h004, 32'h00000007, 2'h0);
		wr(12'h000, 32'h0000F811, 2'h0);
		pwr(1'b0, 1'b0);
		u_edpc_link_partner.pulses = 0;
		wr(12'h000, 32'h0000F811, 2'h0);
		pwr(1'b1, 1'b0);
		repeat (100) @(posedge aclk);
		chk(u_edpc_link_partner.pulses, 1);
		rd(12'h000, 32'h0000EC11, 2'h0);
	endtask
	task t_thresh;
		wr(12'h000, 32'h0000F023, 2'h0);
		pwr(1'b0, 1'b0);
		// Error events do not restart the idle window; a data event does
		u_edpc_link_partner.send(1'b0, 1, 0);
		u_edpc_link_partner.send(1'b1, 2, 3);
		pwr(1'b0, 1'b1);
		rd(12'h000, 32'h0000E223, 2'h0);
		rd(12'h000, 32'h0000E023, 2'h0);
		u_edpc_link_partner.send(1'b0, 1, 0);
		pwr(1'b0, 1'b1);
		u_edpc_link_partner.send(1'b0, 1, 5);
		pwr(1'b1, 1'b0);
	endtask
	task t_idle;
		wr(12'h000, 32'h0000F023, 2'h0);
		pwr(1'b0, 1'b0);
		u_edpc_link_partner.send(1'b0, 2, 80);
		u_edpc_link_partner.send(1'b0, 1, 0);
		pwr(1'b0, 1'b1);
		u_edpc_link_partner.send(1'b0, 2, 0);
		pwr(1'b1, 1'b0);
		rd(12'h000, 32'h0000E523, 2'h0);
	endtask
	task t_disable;
		wr(12'h000, 32'h00006011, 2'h0);
		u_edpc_link_partner.quiet(3);
		pwr(1'b1, 1'b1);
		wr(12'h000, 32'h00007011, 2'h0);
		pwr(1'b1, 1'b1);
		rd(12'h000, 32'h00006411, 2'h0);
	endtask
	// Second reset with the strap low: enable comes up clear, then software sets it
	task t_strap;
		energy_detect_strap <= 1'b0;
		aresetn <= 1'b0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rd(12'h000, 32'h00006411, 2'h0);
		wr(12'h000, 32'h0000E011, 2'h0);
		rd(12'h000, 32'h0000E411, 2'h0);
	endtask
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		// Strap lands on the first edge after release, so skip it
		repeat (2) @(posedge aclk);
		t_reset;
		t_auto;
		t_manual;
		t_thresh;
		t_idle;
		t_disable;
		t_strap;
		wrap_up;
	end
	initial begin
		repeat (20000) @(posedge aclk);
		failures++;
		wrap_up;
	end
endmodule // edpc_tb_top
`default_nettype wire
